// File: rtl/crt_dot_ser.sv
`timescale 1ns/1ps
`default_nettype none
module crt_dot_ser
	import crt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	crt_dot_if.ser dl
);
	logic [GLYPH_W-1:0] glyph_q;
	logic dot_q;
	logic [2:0] idx;

	// ------------------------------------------------------------
	// row register, loaded at column edge time
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			glyph_q <= '0;
		end else if (dl.load) begin
			glyph_q <= dl.glyph;
		end
	end

	// ------------------------------------------------------------
	// one dot per clock, leftmost dot first
	// ------------------------------------------------------------
	assign idx = 3'(GLYPH_W - int'(dl.col));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dot_q <= 1'b0;
		end else begin
			dot_q <= !dl.blank && (glyph_q[idx] || dl.cursor);
		end
	end

	assign dl.dot = dot_q;
endmodule : crt_dot_ser
`default_nettype wire

// File: rtl/crt_if.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// dot serialiser link
// ------------------------------------------------------------
interface crt_dot_if;
	logic load;
	logic [6:0] glyph;
	logic [3:0] col;
	logic blank;
	logic cursor;
	logic dot;
	modport drv(output load, output glyph, output col, output blank,
		output cursor, input dot);
	modport ser(input load, input glyph, input col, input blank,
		input cursor, output dot);
endinterface : crt_dot_if

// ------------------------------------------------------------
// valid/ready word stream
// ------------------------------------------------------------
interface crt_strm_if;
	logic valid;
	logic ready;
	logic [6:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : crt_strm_if
`default_nettype wire

// File: rtl/crt_pair_buf.sv
`timescale 1ns/1ps
`default_nettype none
module crt_pair_buf
	import crt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	crt_strm_if.snk in_s,
	output logic out_valid,
	input wire logic out_ready,
	output logic [CODE_W-1:0] out_data
);
	crt_buf_t fill_q;
	logic [CODE_W-1:0] head_q;
	logic [CODE_W-1:0] tail_q;
	logic push;
	logic pop;

	assign in_s.ready = (fill_q != CRT_BUF_FULL);
	assign push = in_s.valid && in_s.ready;
	assign pop = (fill_q != CRT_BUF_EMPTY) && out_ready;

	// ------------------------------------------------------------
	// two entries, head feeds the output
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fill_q <= CRT_BUF_EMPTY;
			head_q <= '0;
			tail_q <= '0;
		end else begin
			case (fill_q)
				CRT_BUF_EMPTY: begin
					if (push) begin
						head_q <= in_s.data;
						fill_q <= CRT_BUF_ONE;
					end
				end
				CRT_BUF_ONE: begin
					if (push && pop) begin
						head_q <= in_s.data;
					end else if (push) begin
						tail_q <= in_s.data;
						fill_q <= CRT_BUF_FULL;
					end else if (pop) begin
						fill_q <= CRT_BUF_EMPTY;
					end
				end
				CRT_BUF_FULL: begin
					if (pop) begin
						head_q <= tail_q;
						fill_q <= CRT_BUF_ONE;
					end
				end
				default: begin
					fill_q <= CRT_BUF_EMPTY;
				end
			endcase
		end
	end

	assign out_valid = (fill_q != CRT_BUF_EMPTY);
	assign out_data = head_q;
endmodule : crt_pair_buf
`default_nettype wire

// File: rtl/crt_pkg.sv
package crt_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int CODE_W = 7;
	localparam int GLYPH_W = 7;
	localparam int ADDR_W = 10;
	localparam int POS_W = 6;
	localparam int LINE_W = 4;
	localparam int ROW_W = 4;
	localparam int COL_W = 4;
	localparam int BLINK_W = 5;
	localparam int BLINK_BIT = 4;
	// ------------------------------------------------------------
	// oscillator and screen
	// ------------------------------------------------------------
	localparam int OSC_HZ = 5000000;
	localparam int REFRESH_HZ = 60;
	localparam int SCREEN_CHARS = 640;
	// ------------------------------------------------------------
	// counter limits
	// ------------------------------------------------------------
	localparam logic [COL_W-1:0] COL_FIRST = 4'h0;
	localparam logic [COL_W-1:0] COL_LAST = 4'h8;
	localparam logic [COL_W-1:0] COL_ONE = 4'h1;
	localparam logic [POS_W-1:0] POS_FIRST = 6'h00;
	localparam logic [POS_W-1:0] POS_LAST = 6'h27;
	localparam logic [POS_W-1:0] POS_ONE = 6'h01;
	localparam logic [ROW_W-1:0] ROW_FIRST = 4'h2;
	localparam logic [ROW_W-1:0] ROW_LAST = 4'he;
	localparam logic [ROW_W-1:0] ROW_ONE = 4'h1;
	localparam logic [ROW_W-1:0] CURSOR_ROW = 4'h2;
	localparam logic [LINE_W-1:0] LINE_FIRST = 4'h0;
	localparam logic [LINE_W-1:0] LINE_LAST = 4'hf;
	localparam logic [LINE_W-1:0] LINE_ONE = 4'h1;
	localparam logic [1:0] HOLD_CYCLES = 2'h2;
	localparam logic [1:0] HOLD_ONE = 2'h1;
	localparam logic [1:0] HOLD_NONE = 2'h0;
	localparam logic [BLINK_W-1:0] BLINK_ONE = 5'h01;
	localparam logic [CODE_W-1:0] ERASE_CODE = 7'h20;
	// ------------------------------------------------------------
	// buffer occupancy
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CRT_BUF_EMPTY,
		CRT_BUF_ONE,
		CRT_BUF_FULL
	} crt_buf_t;
endpackage : crt_pkg

// File: rtl/crt_raster.sv
// What this block does
// - screen of 16 lines by 40 characters, 640 places, 60 Hz refresh
// - whole chain runs from one 5.0 MHz oscillator
// - every stage on the common clock, stages advance by enables
// - dot column counts 0 to 8, dots 1 to 7 shown on counts 1-7
// - beam blanked on column counts 0 and 8
// - decode column-zero, column-eight and their OR strobes
// - trace start held off two clocks after retrace ends
// - retrace bypasses column stage, position advances every clock
// - character position counts 0 to 39
// - horizontal retrace toggles on each full position count
// - retrace shifts out the other 40 codes of the 80-stage store
// - dot row counts 2 to 14, advances at end of trace count
// - shift inhibit flag loaded per row, set when last row done
// - character line counts 0 to 15 on row and position completion
// - vertical retrace set at last line, cleared when hretrace ends
// - master clear puts timing into a known state
// - retrace drives deflection outputs and forces beam off
// - glyph row serialised onto beam, one dot per clock
// - address equality with pending write starts write cycle
// - equality with pending read captures code; equality enables cursor
// - frame without equality or request erases the screen
// - blinking cursor on dot row 2 of held address
// - write disables storage recirculation to shift new code in
// - storage shift strobe held at 0 when no shift wanted
// - row select value maps in binary order to glyph rows
// - row window spans 13 rows for descending glyphs
`timescale 1ns/1ps
`default_nettype none
module crt_raster
	import crt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [CODE_W-1:0] char_code_in,
	input wire logic [GLYPH_W-1:0] glyph_row_in,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [CODE_W-1:0] req_data,
	output logic req_ready,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [CODE_W-1:0] rd_data,
	output logic [ROW_W-1:0] row_select,
	output logic [POS_W-1:0] char_pos,
	output logic [LINE_W-1:0] char_line,
	output logic column_zero_strobe,
	output logic column_eight_strobe,
	output logic column_edge_strobe,
	output logic storage_shift,
	output logic storage_write,
	output logic [CODE_W-1:0] storage_data,
	output logic x_retrace,
	output logic y_retrace,
	output logic z_beam,
	output logic erase_active
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [COL_W-1:0] col_q;
	logic [COL_W-1:0] col_d;
	logic [POS_W-1:0] pos_q;
	logic [ROW_W-1:0] row_q;
	logic [LINE_W-1:0] line_q;
	logic [1:0] hold_q;
	logic hret_q;
	logic vret_q;
	logic shift_inh_q;
	logic col_zero_q;
	logic col_eight_q;
	logic col_edge_q;
	logic shift_q;
	logic shift_d;
	logic trace_shift;
	logic wr_q;
	logic [CODE_W-1:0] wr_data_q;
	logic pend_q;
	logic pend_wr_q;
	logic [ADDR_W-1:0] addr_q;
	logic [CODE_W-1:0] data_q;
	logic ready_q;
	logic frame_hit_q;
	logic erase_q;
	logic [BLINK_W-1:0] blink_q;
	logic col_en;
	logic pos_en;
	logic pos_wrap;
	logic row_adv;
	logic line_adv;
	logic frame_end;
	logic hret_end;
	logic here;
	logic match;
	logic take_wr;
	logic take_rd;
	logic rd_done;
	logic accept;

	crt_dot_if dl ();
	crt_strm_if rd_s ();

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic col_is(input logic [COL_W-1:0] c,
		input logic [COL_W-1:0] v);
		col_is = (c == v);
	endfunction : col_is

	function automatic logic col_edge(input logic [COL_W-1:0] c);
		col_edge = col_is(c, COL_FIRST) || col_is(c, COL_LAST);
	endfunction : col_edge

	// ------------------------------------------------------------
	// stage enables
	// ------------------------------------------------------------
	// all stages share clk; carries are enables only
	assign col_en = !hret_q && (hold_q == HOLD_NONE);
	assign pos_en = hret_q || (col_en && col_is(col_q, COL_LAST));
	assign pos_wrap = pos_en && (pos_q == POS_LAST);
	assign hret_end = hret_q && pos_wrap;
	assign row_adv = pos_wrap && !hret_q;
	assign line_adv = row_adv && (row_q == ROW_LAST);
	assign frame_end = line_adv && (line_q == LINE_LAST);

	// ------------------------------------------------------------
	// dot column stage
	// ------------------------------------------------------------
	always_comb begin
		col_d = col_q;
		if (col_en) begin
			if (col_is(col_q, COL_LAST)) begin
				col_d = COL_FIRST;
			end else begin
				col_d = col_q + COL_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			col_q <= COL_FIRST;
		end else begin
			col_q <= col_d;
		end
	end

	// ------------------------------------------------------------
	// column timing strobes
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			col_zero_q <= 1'b0;
			col_eight_q <= 1'b0;
			col_edge_q <= 1'b0;
		end else begin
			col_zero_q <= col_is(col_d, COL_FIRST);
			col_eight_q <= col_is(col_d, COL_LAST);
			col_edge_q <= col_edge(col_d);
		end
	end

	// ------------------------------------------------------------
	// trace start hold-off
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_q <= HOLD_NONE;
		end else if (hret_end) begin
			hold_q <= HOLD_CYCLES;
		end else if (hold_q != HOLD_NONE) begin
			hold_q <= hold_q - HOLD_ONE;
		end
	end

	// ------------------------------------------------------------
	// character position stage
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pos_q <= POS_FIRST;
		end else if (pos_wrap) begin
			pos_q <= POS_FIRST;
		end else if (pos_en) begin
			pos_q <= pos_q + POS_ONE;
		end
	end

	// ------------------------------------------------------------
	// horizontal and vertical retrace
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hret_q <= 1'b0;
		end else if (pos_wrap) begin
			hret_q <= !hret_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vret_q <= 1'b0;
		end else if (frame_end) begin
			vret_q <= 1'b1;
		end else if (hret_end) begin
			vret_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// dot row stage, 13-row window
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			row_q <= ROW_FIRST;
		end else if (row_adv) begin
			if (row_q == ROW_LAST) begin
				row_q <= ROW_FIRST;
			end else begin
				row_q <= row_q + ROW_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_inh_q <= 1'b0;
		end else if (row_adv) begin
			shift_inh_q <= (row_q == ROW_LAST);
		end
	end

	// ------------------------------------------------------------
	// character line stage
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_q <= LINE_FIRST;
		end else if (line_adv) begin
			// 16 lines of 40 places, 640 in all
			line_q <= line_q + LINE_ONE;
		end
	end

	// ------------------------------------------------------------
	// storage shift strobe
	// ------------------------------------------------------------
	assign trace_shift = col_en && col_is(col_q, COL_LAST);
	assign shift_d = trace_shift || (hret_q && !shift_inh_q);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q <= 1'b0;
		end else begin
			// retrace shifting moves the other 40 codes
			shift_q <= shift_d;
		end
	end

	// ------------------------------------------------------------
	// request holding registers
	// ------------------------------------------------------------
	assign accept = req_valid && ready_q;
	assign here = (addr_q == {line_q, pos_q});
	assign match = !hret_q && col_en && col_is(col_q, COL_FIRST) && here;
	assign take_wr = match && pend_q && pend_wr_q;
	assign take_rd = match && pend_q && !pend_wr_q;
	assign rd_done = take_rd && rd_s.ready;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_q <= '0;
			data_q <= '0;
			pend_wr_q <= 1'b0;
		end else if (accept) begin
			addr_q <= req_addr;
			data_q <= req_data;
			pend_wr_q <= req_write;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
			ready_q <= 1'b0;
		end else if (accept) begin
			pend_q <= 1'b1;
			ready_q <= 1'b0;
		end else if (take_wr || rd_done) begin
			pend_q <= 1'b0;
			ready_q <= 1'b1;
		end else begin
			ready_q <= !pend_q;
		end
	end

	// ------------------------------------------------------------
	// write cycle and erase
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= 1'b0;
			wr_data_q <= '0;
		end else if (take_wr) begin
			wr_q <= 1'b1;
			wr_data_q <= data_q;
		end else if (erase_q) begin
			wr_q <= 1'b1;
			wr_data_q <= ERASE_CODE;
		end else if (trace_shift) begin
			wr_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_hit_q <= 1'b0;
			erase_q <= 1'b0;
		end else if (frame_end) begin
			frame_hit_q <= match;
			erase_q <= !(frame_hit_q || match) && !pend_q;
		end else if (match) begin
			frame_hit_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// read capture into the two-entry buffer
	// ------------------------------------------------------------
	assign rd_s.valid = take_rd;
	assign rd_s.data = char_code_in;

	crt_pair_buf u_buf (
		.clk(clk),
		.rst_b(rst_b),
		.in_s(rd_s),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// ------------------------------------------------------------
	// cursor blink and beam
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			blink_q <= '0;
		end else if (frame_end) begin
			blink_q <= blink_q + BLINK_ONE;
		end
	end

	assign dl.load = col_en && col_edge(col_q);
	assign dl.glyph = glyph_row_in;
	assign dl.col = col_q;
	assign dl.blank = hret_q || vret_q || col_edge(col_q);
	assign dl.cursor = here && (row_q == CURSOR_ROW) && blink_q[BLINK_BIT];

	crt_dot_ser u_ser (
		.clk(clk),
		.rst_b(rst_b),
		.dl(dl)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// one 5.0 MHz oscillator for all stages
	assign row_select = row_q;
	assign char_pos = pos_q;
	assign char_line = line_q;
	assign column_zero_strobe = col_zero_q;
	assign column_eight_strobe = col_eight_q;
	assign column_edge_strobe = col_edge_q;
	assign storage_shift = shift_q;
	assign storage_write = wr_q;
	assign storage_data = wr_data_q;
	assign x_retrace = hret_q;
	assign y_retrace = vret_q;
	assign z_beam = dl.dot;
	assign erase_active = erase_q;
	assign req_ready = ready_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	col_range_a: assert property (col_q <= COL_LAST)
		else $error("dot column out of range");
	beam_retrace_a: assert property (hret_q |=> !z_beam)
		else $error("beam on during retrace");
	hret_toggle_a: assert property (pos_wrap |=> hret_q != $past(hret_q))
		else $error("retrace did not toggle");
	trace_hold_a: assert property ($fell(hret_q) |->
		(col_q == COL_FIRST) [*3] ##1 (col_q == COL_ONE))
		else $error("trace hold-off wrong");
	fast_pos_a: assert property ((hret_q && pos_q != POS_LAST) |=>
		pos_q == $past(pos_q) + POS_ONE)
		else $error("retrace position not advancing");
	row_range_a: assert property (row_q >= ROW_FIRST && row_q <= ROW_LAST)
		else $error("dot row out of range");
	shift_idle_a: assert property ((!hret_q && !trace_shift) |=>
		!storage_shift)
		else $error("shift strobe without cause");
	retrace_shift_a: assert property ((hret_q && !shift_inh_q) |=>
		storage_shift)
		else $error("retrace shift missing");
	vret_clear_a: assert property ($fell(hret_q) |-> !vret_q)
		else $error("vertical retrace not cleared");
	write_start_a: assert property (take_wr |=> storage_write &&
		storage_data == $past(data_q))
		else $error("write not started on match");
	read_done_a: assert property (rd_done |=> !pend_q && rd_valid)
		else $error("read capture lost");

	frame_c: cover property (frame_end);
	write_c: cover property (take_wr);
	read_c: cover property (rd_done);
	erase_c: cover property (erase_q);
endmodule : crt_raster
`default_nettype wire

// File: verification/crt_mon.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// monitor deflection and beam inputs
// ------------------------------------------------------------
module crt_mon (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic x_retrace,
	input wire logic y_retrace,
	input wire logic z_beam,
	output logic [15:0] hret_len,
	output logic [15:0] htrace_len,
	output logic [15:0] vret_len,
	output logic [15:0] dots_row,
	output logic [15:0] beam_bad
);
	logic x_q;
	logic [15:0] run_q;
	logic [15:0] yrun_q;
	logic [15:0] dots_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			x_q <= 1'b0;
			run_q <= '0;
			yrun_q <= '0;
			dots_q <= '0;
			hret_len <= '0;
			htrace_len <= '0;
			vret_len <= '0;
			dots_row <= '0;
			beam_bad <= '0;
		end else begin
			x_q <= x_retrace;
			run_q <= (x_retrace != x_q) ? 16'h0001 : run_q + 16'h0001;
			yrun_q <= y_retrace ? yrun_q + 16'h0001 : '0;
			if (!y_retrace && yrun_q != '0)
				vret_len <= yrun_q;
			if (x_retrace && !x_q) begin
				htrace_len <= run_q;
				dots_row <= dots_q;
				dots_q <= '0;
			end else if (!x_retrace && z_beam)
				dots_q <= dots_q + 16'h0001;
			if (!x_retrace && x_q)
				hret_len <= run_q;
			if (z_beam && (x_retrace || y_retrace))
				beam_bad <= beam_bad + 16'h0001;
		end
	end
endmodule : crt_mon
`default_nettype wire

// File: verification/crt_raster_timing_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module crt_raster_timing_counter_bench;
	import crt_pkg::*;
	typedef struct {
		logic [GLYPH_W-1:0] g;
		logic [15:0] dots;
	} crt_row_t;
	localparam int CYC_MAX = 95000;
	logic clk, rst_b, req_valid, req_write, rd_ready, req_ready, rd_valid;
	logic column_zero_strobe, column_eight_strobe, column_edge_strobe;
	logic storage_shift, storage_write, x_retrace, y_retrace, z_beam;
	logic erase_active, xq, seen, inh;
	logic [CODE_W-1:0] char_code_in, req_data, rd_data, storage_data;
	logic [GLYPH_W-1:0] glyph_row_in;
	logic [ADDR_W-1:0] req_addr;
	logic [ROW_W-1:0] row_select, prow;
	logic [POS_W-1:0] char_pos;
	logic [LINE_W-1:0] char_line, pline;
	logic [15:0] hret_len, htrace_len, vret_len, dots_row, beam_bad;
	int miscompares, n_compared, cyc, sh, i;
	crt_row_t tbl [4] = '{'{7'h7f, 16'd280}, '{7'h41, 16'd80},
		'{7'h00, 16'd0}, '{7'h55, 16'd160}};
	crt_raster DUT (.clk, .rst_b, .char_code_in, .glyph_row_in, .req_valid,
		.req_write, .req_addr, .req_data, .req_ready, .rd_valid, .rd_ready,
		.rd_data, .row_select, .char_pos, .char_line, .column_zero_strobe,
		.column_eight_strobe, .column_edge_strobe, .storage_shift,
		.storage_write, .storage_data, .x_retrace, .y_retrace, .z_beam,
		.erase_active);
	crt_mon mon (.clk, .rst_b, .x_retrace, .y_retrace, .z_beam, .hret_len,
		.htrace_len, .vret_len, .dots_row, .beam_bad);
	// ------------------------------------------------------------
	// clock, storage model, shared tasks
	// ------------------------------------------------------------
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(posedge clk) begin
		#1;
		char_code_in = {char_line[2:0], char_pos[3:0]};
	end
	task automatic chk(input bit ok, input string msg);
		n_compared++;
		if (!ok) begin
			miscompares++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic req(input logic w, input logic [ADDR_W-1:0] a,
		input logic [CODE_W-1:0] d);
		logic rdy;
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_data = d;
		// ready is a flop: its value before the edge is what the edge takes
		do begin
			@(negedge clk);
			rdy = req_ready;
			@(posedge clk);
		end while (rdy !== 1'b1);
		#1;
		req_valid = 1'b0;
	endtask : req
	// ------------------------------------------------------------
	// per-cycle watch: strobes, row sequence, shifts, timeout
	// ------------------------------------------------------------
	always @(negedge clk) begin
		cyc++;
		if (cyc == CYC_MAX) begin
			miscompares++;
			wrap_up();
		end else if (rst_b === 1'b1) begin
			chk(column_edge_strobe === (column_zero_strobe |
				column_eight_strobe), "edge strobe");
			if (x_retrace === 1'b1 && xq === 1'b0) begin
				if (seen) begin
					chk(sh === (inh ? 40 : 80), "shifts per row");
					chk(row_select === ((prow == ROW_LAST) ? ROW_FIRST :
						prow + ROW_ONE), "row step");
					chk(char_line === ((prow == ROW_LAST) ?
						pline + LINE_ONE : pline), "line step");
				end
				seen = 1'b1;
				inh = (row_select == ROW_FIRST);
				prow = row_select;
				pline = char_line;
				sh = int'(storage_shift);
			end else
				sh += int'(storage_shift);
			xq = x_retrace;
		end else begin
			seen = 1'b0;
			xq = 1'b0;
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_data = '0;
		rd_ready = 1'b0;
		glyph_row_in = '0;
		char_code_in = '0;
		repeat (12) @(posedge clk);
		#1 rst_b = 1'b1;
		for (i = 0; i < 4; i++) begin
			@(posedge x_retrace);
			#1 glyph_row_in = tbl[i].g;
			@(posedge x_retrace);
			@(posedge clk);
			#1;
			chk(dots_row === tbl[i].dots, "dots in row");
			chk(htrace_len === 16'd362, "trace length");
			chk(hret_len === 16'd40, "retrace length");
		end
		req(1'b1, {4'h1, 6'h05}, 7'h5a);
		do @(negedge clk); while (storage_write !== 1'b1);
		chk(storage_data === 7'h5a && char_pos === 6'h05 &&
			char_line === 4'h1, "write place");
		req(1'b0, {4'h2, 6'h07}, 7'h00);
		req(1'b0, {4'h3, 6'h03}, 7'h00);
		req(1'b0, {4'h4, 6'h00}, 7'h00);
		do @(negedge clk); while (char_line !== 4'h5);
		chk(req_ready === 1'b0 && rd_valid === 1'b1, "full buffer");
		chk(rd_data === 7'h27, "first read");
		@(posedge clk);
		#1 rd_ready = 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk(rd_data === 7'h33 && rd_valid === 1'b1, "second read");
		@(posedge clk);
		#1 rd_ready = 1'b0;
		@(negedge clk);
		chk(rd_valid === 1'b0, "buffer drained");
		do @(posedge clk); while (y_retrace !== 1'b1);
		do @(posedge clk); while (y_retrace !== 1'b0);
		@(posedge clk);
		#1;
		chk(vret_len === 16'd40, "vertical retrace");
		chk(beam_bad === 16'd0, "beam in retrace");
		chk(erase_active === 1'b0, "erase after hit");
		rst_b = 1'b0;
		@(posedge clk);
		#1;
		chk({char_pos, char_line, row_select} ===
			{POS_FIRST, LINE_FIRST, ROW_FIRST}, "count clear");
		chk({x_retrace, y_retrace, z_beam, storage_shift, req_ready,
			rd_valid} === 6'h00, "flag clear");
		wrap_up();
	end
endmodule : crt_raster_timing_counter_bench
`default_nettype wire
